// [logic/frbs_ctl.sv]
`timescale 1ns/100ps
`include "frbs_regs.svh"
// controller end: runs boot selection, programs entries, runs updates
module frbs_ctl
  import frbs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // link to the device
  frbs_link_if.ctl link,
  // user: slot verify hook results and image sizes
  input wire logic hook_ok0,
  input wire logic hook_ok1,
  input wire logic [31:0] img0_size,
  input wire logic [31:0] img1_size,
  // user: boot request and status
  input wire logic start_boot,
  output logic booted,
  output logic boot_failed,
  output logic active_slot,
  // user: update control
  input wire logic upd_start,
  input wire logic upd_csum_valid,
  input wire logic upd_csum_ok,
  output logic upd_busy,
  output logic upd_target,
  output logic upd_aborted,
  // user: user entries 2..7 programming
  input wire logic user_we,
  input wire logic [2:0] user_idx,
  input frbs_entry_t user_entry,
  // user: fetch
  input wire logic [31:0] fetch_vaddr,
  output logic [31:0] fetch_paddr
);
  typedef struct packed {
    logic [31:0] sig0;
    logic [31:0] sig1;
    logic req;
    logic armed; // request has stood one cycle, so the device answer is fresh
    logic [1:0] prog_step;
    logic booted;
    logic failed;
    logic slot;
    frbs_up_state_t up;
    logic target;
    logic aborted;
  } frbs_ctl_state_t;

  frbs_ctl_state_t s_reg;
  frbs_ctl_state_t s_next;
  logic [31:0] base; // physical start of active slot

  assign base = s_reg.slot ? `FRBS_SLOT1_BASE : `FRBS_SLOT0_BASE;

  // next-state logic
  always_comb begin
    s_next = s_reg;
    link.prog_we = 1'b0;
    link.prog_idx = 3'h0;
    link.prog_start = `FRBS_DISABLED_ADDR;
    link.prog_end = `FRBS_DISABLED_ADDR;
    link.prog_offset = `FRBS_SIG_ERASED;
    link.prog_sub = 1'b1;
    if (start_boot && !s_reg.req) begin
      s_next.req = 1'b1;
      s_next.booted = 1'b0;
      s_next.failed = 1'b0;
    end
    // the device keeps the previous verdict until it has seen the new request,
    // so the first cycle of a request must not be read as an answer
    s_next.armed = s_reg.req;
    if (s_reg.req && s_reg.armed && link.boot_fail) begin
      s_next.failed = 1'b1;
      s_next.req = 1'b0;
    end
    if (s_reg.req && s_reg.armed && link.boot_done) begin
      s_next.slot = link.boot_slot;
      s_next.req = 1'b0;
      s_next.prog_step = 2'h1;
    end
    // two entry writes after selection, then mark booted
    case (s_reg.prog_step)
      2'h1: begin
        link.prog_we = 1'b1;
        link.prog_idx = 3'h0;
        link.prog_start = `FRBS_VWIN0;
        link.prog_end = `FRBS_VWIN0 + img0_size;
        link.prog_offset = `FRBS_VWIN0 - base; // see R6 R7
        s_next.prog_step = 2'h2;
      end
      2'h2: begin
        link.prog_we = 1'b1;
        link.prog_idx = 3'h1;
        link.prog_start = `FRBS_VWIN1;
        link.prog_end = `FRBS_VWIN1 + img1_size;
        // second image follows the first in the same slot
        link.prog_offset = `FRBS_VWIN1 - (base + img0_size); // see R8
        s_next.prog_step = 2'h0;
        s_next.booted = 1'b1;
      end
      default: begin
        // user writes only reach entries above the reserved pair
        if (user_we && user_idx >= 3'h2) begin // see R9
          link.prog_we = 1'b1;
          link.prog_idx = user_idx;
          link.prog_start = user_entry.start_addr;
          link.prog_end = user_entry.end_addr;
          link.prog_offset = user_entry.offset;
          link.prog_sub = user_entry.subtract;
        end
      end
    endcase
    // updater sequence
    case (s_reg.up)
      FRBS_UP_IDLE: begin
        if (upd_start) begin
          s_next.target = !s_reg.slot; // see R14
          s_next.aborted = 1'b0;
          s_next.up = FRBS_UP_WAIT;
        end
      end
      FRBS_UP_WAIT: begin
        if (upd_csum_valid) begin
          s_next.aborted = !upd_csum_ok; // see R15
          s_next.up = upd_csum_ok ? FRBS_UP_SIGN : FRBS_UP_IDLE;
        end
      end
      FRBS_UP_SIGN: begin
        if (s_reg.target) s_next.sig1 = `FRBS_SIGNATURE; // see R16
        else s_next.sig0 = `FRBS_SIGNATURE;
        s_next.up = FRBS_UP_ERASE;
      end
      FRBS_UP_ERASE: begin
        if (s_reg.target) s_next.sig0 = `FRBS_SIG_ERASED; // see R16
        else s_next.sig1 = `FRBS_SIG_ERASED;
        s_next.up = FRBS_UP_DONE;
      end
      FRBS_UP_DONE: begin
        s_next.up = FRBS_UP_IDLE;
      end
      default: begin
        s_next.up = FRBS_UP_IDLE;
      end
    endcase
  end

  // register; signatures start erased so a fresh part reports failure
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_reg <= '0;
      s_reg.up <= FRBS_UP_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // link drive
  assign link.boot_req = s_reg.req;
  assign link.sig0 = s_reg.sig0;
  assign link.sig1 = s_reg.sig1;
  assign link.hash_ok0 = hook_ok0;
  assign link.hash_ok1 = hook_ok1;
  assign link.vaddr = fetch_vaddr;
  // user outputs
  assign fetch_paddr = link.paddr;
  assign booted = s_reg.booted;
  assign boot_failed = s_reg.failed;
  assign active_slot = s_reg.slot;
  assign upd_busy = (s_reg.up != FRBS_UP_IDLE);
  assign upd_target = s_reg.target;
  assign upd_aborted = s_reg.aborted;
endmodule

// [logic/frbs_dev.sv]
`timescale 1ns/100ps
`include "frbs_regs.svh"
// How it works
// R1: translate virtual fetch addresses to physical flash
// R2: eight entries with start and end bounds
// R3: unmatched address passes through unchanged
// R4: matched address adds or subtracts entry offset
// R5: one entry moves several consecutive pages
// R6: first slot: entry0 subtracts to 0x08006000
// R7: second slot: entry0 subtracts to 0x08106000
// R8: entry1 maps second core window at 0x0e000000
// R9: entries two to seven left for users
// R10: slot valid only with signature and hash
// R11: no valid slot means boot failure
// R12: one valid slot boots that slot
// R13: both valid boots the second slot
// R14: updater writes the inactive slot
// R15: failed checksum aborts, signatures untouched
// R16: good checksum signs new, zeroes old signature
// R17: all-ones start and end disables entry
// R18: lowest index wins on overlap
module frbs_dev
  import frbs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // link to the controller
  frbs_link_if.dev link
);
  // whole device state
  typedef struct packed {
    frbs_entry_t [`FRBS_ENTRIES-1:0] ent;
    frbs_boot_state_t st;
    logic done;
    logic fail;
    logic slot;
    logic [31:0] paddr;
    logic hit;
  } frbs_dev_state_t;

  frbs_dev_state_t state_reg;
  frbs_dev_state_t state_next;
  frbs_entry_t ent_arr [`FRBS_ENTRIES]; // unpacked view for the matcher
  logic [31:0] xl_paddr; // matcher result
  logic xl_hit;
  logic ok0; // first slot valid
  logic ok1; // second slot valid

  for (genvar g = 0; g < `FRBS_ENTRIES; g++) begin : g_view
    assign ent_arr[g] = state_reg.ent[g];
  end

  frbs_xlate frbs_xlate_inst (
    .entries(ent_arr),
    .vaddr(link.vaddr),
    .paddr(xl_paddr),
    .hit(xl_hit)
  ); // see R1

  // signature plus optional verify hook decides validity
  assign ok0 = (link.sig0 == `FRBS_SIGNATURE) && link.hash_ok0; // see R10
  assign ok1 = (link.sig1 == `FRBS_SIGNATURE) && link.hash_ok1; // see R10

  // next-state logic
  always_comb begin
    state_next = state_reg;
    // translated address registered so data outputs come from flops
    state_next.paddr = xl_paddr;
    state_next.hit = xl_hit;
    if (link.prog_we) begin
      state_next.ent[link.prog_idx].start_addr = link.prog_start;
      state_next.ent[link.prog_idx].end_addr = link.prog_end;
      state_next.ent[link.prog_idx].offset = link.prog_offset;
      state_next.ent[link.prog_idx].subtract = link.prog_sub;
    end
    case (state_reg.st)
      FRBS_ST_IDLE: begin
        // a new request reopens the decision
        if (link.boot_req) begin
          state_next.done = 1'b0;
          state_next.fail = 1'b0;
          state_next.st = FRBS_ST_EVAL;
        end
      end
      FRBS_ST_EVAL: begin
        if (!ok0 && !ok1) begin
          state_next.fail = 1'b1; // see R11
          state_next.st = FRBS_ST_FAIL;
        end else begin
          // second slot takes priority when both hold
          state_next.slot = ok1; // see R12 R13
          state_next.done = 1'b1;
          state_next.st = FRBS_ST_DONE;
        end
      end
      FRBS_ST_DONE, FRBS_ST_FAIL: begin
        // result holds until the request drops
        if (!link.boot_req) begin
          state_next.st = FRBS_ST_IDLE;
        end
      end
      default: begin
        state_next.st = FRBS_ST_IDLE;
      end
    endcase
  end

  // register; entries come up disabled so nothing remaps before programming
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < `FRBS_ENTRIES; i++) begin
        state_reg.ent[i].start_addr <= `FRBS_DISABLED_ADDR; // see R17
        state_reg.ent[i].end_addr <= `FRBS_DISABLED_ADDR;
        state_reg.ent[i].offset <= `FRBS_SIG_ERASED;
        state_reg.ent[i].subtract <= 1'b0;
      end
      state_reg.st <= FRBS_ST_IDLE;
      state_reg.done <= 1'b0;
      state_reg.fail <= 1'b0;
      state_reg.slot <= 1'b0;
      state_reg.paddr <= `FRBS_SIG_ERASED;
      state_reg.hit <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs
  assign link.boot_done = state_reg.done;
  assign link.boot_fail = state_reg.fail;
  assign link.boot_slot = state_reg.slot;
  assign link.paddr = state_reg.paddr;
  assign link.hit = state_reg.hit;
endmodule

// [logic/frbs_link_if.sv]
`timescale 1ns/100ps
// link between the remap/boot device and the software-side controller
interface frbs_link_if;
  // entry programming
  logic prog_we;
  logic [2:0] prog_idx;
  logic [31:0] prog_start;
  logic [31:0] prog_end;
  logic [31:0] prog_offset;
  logic prog_sub;
  // slot signatures and verify results fed to the selector
  logic boot_req;
  logic [31:0] sig0;
  logic [31:0] sig1;
  logic hash_ok0;
  logic hash_ok1;
  // selector answer
  logic boot_done;
  logic boot_fail;
  logic boot_slot;
  // translation path
  logic [31:0] vaddr;
  logic [31:0] paddr;
  logic hit;

  modport dev (
    input prog_we, prog_idx, prog_start, prog_end, prog_offset, prog_sub,
    input boot_req, sig0, sig1, hash_ok0, hash_ok1, vaddr,
    output boot_done, boot_fail, boot_slot, paddr, hit
  );
  modport ctl (
    output prog_we, prog_idx, prog_start, prog_end, prog_offset, prog_sub,
    output boot_req, sig0, sig1, hash_ok0, hash_ok1, vaddr,
    input boot_done, boot_fail, boot_slot, paddr, hit
  );
endinterface

// [logic/frbs_pkg.sv]
package frbs_pkg;
  // one translation entry as software programs it
  typedef struct packed {
    logic [31:0] start_addr;
    logic [31:0] end_addr;
    logic [31:0] offset;
    logic subtract;
  } frbs_entry_t;

  // boot selector states, one-hot
  typedef enum logic [3:0] {
    FRBS_ST_IDLE = 4'h1,
    FRBS_ST_EVAL = 4'h2,
    FRBS_ST_DONE = 4'h4,
    FRBS_ST_FAIL = 4'h8
  } frbs_boot_state_t;

  // updater states, one-hot
  typedef enum logic [4:0] {
    FRBS_UP_IDLE = 5'h01,
    FRBS_UP_WAIT = 5'h02,
    FRBS_UP_SIGN = 5'h04,
    FRBS_UP_ERASE = 5'h08,
    FRBS_UP_DONE = 5'h10
  } frbs_up_state_t;
endpackage

// [logic/frbs_regs.svh]
`ifndef FRBS_REGS_SVH
`define FRBS_REGS_SVH
// number of translation entries
`define FRBS_ENTRIES 8
// address width of the fetch path
`define FRBS_AW 32
// entry field that marks a disabled entry (start and end all ones)
`define FRBS_DISABLED_ADDR 32'hffff_ffff
// fixed slot signature value; arbitrary value, not a real part code
`define FRBS_SIGNATURE 32'h5a3c_96e1
// erased signature written into the superseded slot
`define FRBS_SIG_ERASED 32'h0000_0000
// default physical start of the first and second image slot
`define FRBS_SLOT0_BASE 32'h0800_6000
`define FRBS_SLOT1_BASE 32'h0810_6000
// virtual window of the first core image
`define FRBS_VWIN0 32'h0c00_0000
// virtual window of the second core image
`define FRBS_VWIN1 32'h0e00_0000
`endif

// [logic/frbs_xlate.sv]
`timescale 1ns/100ps
`include "frbs_regs.svh"
// combinational range matcher: lowest matching enabled entry wins
module frbs_xlate
  import frbs_pkg::*;
(
  // entry table
  input frbs_entry_t entries [`FRBS_ENTRIES],
  // address in and out
  input wire logic [31:0] vaddr,
  output logic [31:0] paddr,
  output logic hit
);
  // an entry is live unless both bounds are all ones
  function automatic logic entry_live(input frbs_entry_t e);
    return !(e.start_addr == `FRBS_DISABLED_ADDR && e.end_addr == `FRBS_DISABLED_ADDR); // see R17
  endfunction

  logic [`FRBS_ENTRIES-1:0] match; // per-entry range hit

  genvar g;
  generate
    for (g = 0; g < `FRBS_ENTRIES; g++) begin : g_match
      // inclusive range compare
      assign match[g] = entry_live(entries[g]) &&
                        vaddr >= entries[g].start_addr &&
                        vaddr <= entries[g].end_addr; // see R2
    end
  endgenerate

  // walk from the top down so the lowest index is written last
  always_comb begin
    paddr = vaddr; // see R3
    hit = 1'b0;
    for (int i = `FRBS_ENTRIES - 1; i >= 0; i--) begin // see R18
      if (match[i]) begin
        hit = 1'b1;
        // offset may move a whole run of pages at once
        paddr = entries[i].subtract ? vaddr - entries[i].offset
                                    : vaddr + entries[i].offset; // see R4 R5
      end
    end
  end
endmodule

// [testbench/frbs_link_sva.sv]
`timescale 1ns/100ps
`include "frbs_regs.svh"
// watches the link between the remap device and the controller
module frbs_link_sva (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // entry programming
  input wire logic prog_we,
  input wire logic [2:0] prog_idx,
  input wire logic [31:0] prog_start,
  input wire logic [31:0] prog_end,
  input wire logic [31:0] prog_offset,
  input wire logic prog_sub,
  // boot selection
  input wire logic boot_req,
  input wire logic [31:0] sig0,
  input wire logic [31:0] sig1,
  input wire logic hash_ok0,
  input wire logic hash_ok1,
  input wire logic boot_done,
  input wire logic boot_fail,
  input wire logic boot_slot,
  // translation
  input wire logic [31:0] vaddr,
  input wire logic [31:0] paddr,
  input wire logic hit
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // slot validity: signature and hook result together
  wire v0 = sig0 == `FRBS_SIGNATURE && hash_ok0;
  wire v1 = sig1 == `FRBS_SIGNATURE && hash_ok1;
  // shadow of entry 0; lowest index wins, so its range decides alone
  logic [31:0] e0s_reg, e0e_reg, e0o_reg;
  logic e0sub_reg, any_we_reg;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      e0s_reg <= `FRBS_DISABLED_ADDR;
      e0e_reg <= `FRBS_DISABLED_ADDR;
      e0o_reg <= `FRBS_SIG_ERASED;
      e0sub_reg <= 1'b0;
      any_we_reg <= 1'b0;
    end else if (prog_we) begin
      any_we_reg <= 1'b1;
      // only entry 0 is mirrored, enough to judge the winner
      if (prog_idx == 3'h0) begin
        e0s_reg <= prog_start;
        e0e_reg <= prog_end;
        e0o_reg <= prog_offset;
        e0sub_reg <= prog_sub;
      end
    end
  end
  // disabled pattern can never match, even at the top address
  wire in0 = vaddr >= e0s_reg && vaddr <= e0e_reg && e0s_reg != `FRBS_DISABLED_ADDR;
  wire [31:0] xl = e0sub_reg ? vaddr - e0o_reg : vaddr + e0o_reg;
  a_none_fail: assert property ($rose(boot_req) && !v0 && !v1 |-> ##2 boot_fail && !boot_done)
    else $error("boot did not fail with no valid slot");
  a_one_boot: assert property ($rose(boot_req) && (v0 ^ v1) |-> ##2 boot_done && boot_slot == v1)
    else $error("single valid slot not booted");
  a_both_second: assert property ($rose(boot_req) && v0 && v1 |-> ##2 boot_done && boot_slot)
    else $error("second slot not preferred");
  a_miss_pass: assert property (!sys_rst ##1 !hit |-> paddr == $past(vaddr))
    else $error("missed address altered");
  a_disabled_miss: assert property (!any_we_reg |=> !hit)
    else $error("disabled entry matched");
  a_entry0_xlate: assert property (in0 |=> hit && paddr == $past(xl))
    else $error("entry 0 translation wrong");
  a_result_holds: assert property (!boot_req |=> $stable({boot_done, boot_fail, boot_slot}))
    else $error("boot result moved without request");
  a_sign_erase: assert property ($rose(sig1 == `FRBS_SIGNATURE) |=> sig0 == `FRBS_SIG_ERASED)
    else $error("old signature not erased");
  c_fail: cover property ($rose(boot_fail));
  c_slot1: cover property ($rose(boot_done) && boot_slot);
  c_user: cover property (prog_we && prog_idx == 3'h2);
endmodule

// [testbench/test_flash_remap_boot_select.sv]
`timescale 1ns/100ps
`include "frbs_regs.svh"
// drives the controller's user side and checks what the device answers
module test_flash_remap_boot_select import frbs_pkg::*;;
  logic clk, sys_rst, hook_ok0, hook_ok1, start_boot, upd_start;
  logic upd_csum_valid, upd_csum_ok, user_we;
  logic booted, boot_failed, active_slot, upd_busy, upd_target, upd_aborted;
  logic [31:0] img0_size, img1_size, fetch_vaddr, fetch_paddr;
  logic [2:0] user_idx;
  frbs_entry_t user_entry;
  int fails, checks_done;
  frbs_link_if link ();
  frbs_dev frbs_dev_inst (.clk(clk), .sys_rst(sys_rst), .link(link));
  frbs_ctl frbs_ctl_inst (.clk(clk), .sys_rst(sys_rst), .link(link),
    .hook_ok0(hook_ok0), .hook_ok1(hook_ok1), .img0_size(img0_size), .img1_size(img1_size),
    .start_boot(start_boot), .booted(booted), .boot_failed(boot_failed),
    .active_slot(active_slot), .upd_start(upd_start), .upd_csum_valid(upd_csum_valid),
    .upd_csum_ok(upd_csum_ok), .upd_busy(upd_busy), .upd_target(upd_target),
    .upd_aborted(upd_aborted), .user_we(user_we), .user_idx(user_idx),
    .user_entry(user_entry), .fetch_vaddr(fetch_vaddr), .fetch_paddr(fetch_paddr));
  frbs_link_sva frbs_link_sva_inst (.clk(clk), .sys_rst(sys_rst), .prog_we(link.prog_we),
    .prog_idx(link.prog_idx), .prog_start(link.prog_start), .prog_end(link.prog_end),
    .prog_offset(link.prog_offset), .prog_sub(link.prog_sub), .boot_req(link.boot_req),
    .sig0(link.sig0), .sig1(link.sig1), .hash_ok0(link.hash_ok0), .hash_ok1(link.hash_ok1),
    .boot_done(link.boot_done), .boot_fail(link.boot_fail), .boot_slot(link.boot_slot),
    .vaddr(link.vaddr), .paddr(link.paddr), .hit(link.hit));
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // verdict and end of run, also reached by a spent wait
  task automatic results();
    if (fails == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // inputs always move 1 ns after the edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // address held long enough for the registered answer to settle
  task automatic fetch(input logic [31:0] v, input logic [31:0] exp);
    fetch_vaddr = v;
    step(3);
    cmp(fetch_paddr, exp);
  endtask
  // boot walk takes six cycles, three spare
  task automatic boot();
    start_boot = 1'b1;
    step(1);
    start_boot = 1'b0;
    step(8);
  endtask
  task automatic prog(input logic [2:0] idx, input logic [31:0] s, input logic [31:0] e,
      input logic [31:0] o);
    user_idx = idx;
    user_entry = '{s, e, o, 1'b0};
    user_we = 1'b1;
    step(1);
    user_we = 1'b0;
    step(2);
  endtask
  task automatic upd(input logic ok, input logic tgt);
    int i;
    upd_start = 1'b1;
    step(1);
    upd_start = 1'b0;
    cmp(upd_busy, 32'h1);
    cmp(upd_target, tgt);
    upd_csum_ok = ok;
    upd_csum_valid = 1'b1;
    step(1);
    upd_csum_valid = 1'b0;
    for (i = 0; i < 20 && upd_busy !== 1'b0; i++) step(1);
    if (i == 20) begin
      fails++;
      results();
    end
    cmp(upd_aborted, !ok);
  endtask
  initial begin
    {sys_rst, hook_ok0, hook_ok1} = 3'h7;
    {start_boot, upd_start, upd_csum_valid, upd_csum_ok, user_we} = 5'h00;
    user_idx = 3'h2;
    user_entry = '0;
    fetch_vaddr = '0;
    img0_size = 32'h0000_8000;
    img1_size = 32'h0002_0000;
    fails = 0;
    checks_done = 0;
    step(10);
    sys_rst = 1'b0;
    fetch(`FRBS_VWIN0, `FRBS_VWIN0);
    boot();
    cmp(boot_failed, 32'h1);
    cmp(booted, 32'h0);
    upd(1'b0, 1'b1);
    cmp(link.sig1, `FRBS_SIG_ERASED);
    upd(1'b1, 1'b1);
    cmp(link.sig1, `FRBS_SIGNATURE);
    cmp(link.sig0, `FRBS_SIG_ERASED);
    boot();
    cmp(active_slot, 32'h1);
    fetch(`FRBS_VWIN0, `FRBS_SLOT1_BASE);
    fetch(`FRBS_VWIN1, `FRBS_SLOT1_BASE + img0_size);
    fetch(`FRBS_VWIN0 + img0_size, `FRBS_SLOT1_BASE + img0_size);
    fetch(`FRBS_VWIN0 + img0_size + 1, `FRBS_VWIN0 + img0_size + 1);
    prog(3'h3, 32'h1000_0000, 32'h1000_3fff, 32'h0000_4000);
    fetch(32'h1000_2abc, 32'h1000_6abc);
    prog(3'h2, `FRBS_VWIN0, `FRBS_VWIN0 + 32'h10, 32'h0000_0100);
    fetch(`FRBS_VWIN0, `FRBS_SLOT1_BASE);
    prog(3'h1, `FRBS_VWIN1, `FRBS_VWIN1, 32'h0000_0100);
    fetch(`FRBS_VWIN1, `FRBS_SLOT1_BASE + img0_size);
    upd(1'b1, 1'b0);
    cmp(link.sig0, `FRBS_SIGNATURE);
    hook_ok0 = 1'b0;
    boot();
    cmp(boot_failed, 32'h1);
    hook_ok0 = 1'b1;
    boot();
    cmp(active_slot, 32'h0);
    fetch(`FRBS_VWIN0, `FRBS_SLOT0_BASE);
    results();
  end
endmodule
